/* File: logic/dabd_decoder.sv */
`timescale 1ns/100ps

module dabd_decoder (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  input  wire logic [15:0]           instr_i,
  input  wire logic                  instr_valid_i,
  output logic                       instr_ready_o,
  input  wire dabd_pkg::dabd_cond_s  cond_i,
  output dabd_pkg::dabd_result_s     result_o,
  output logic                       done_o,
  input  wire logic [1:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic [31:0]                avs_readdata_o,
  output logic                       avs_waitrequest_o
);

  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_OPERAND,
    ST_EXEC
  } dabd_state_e;

  // =========================================================
  // opcode match
  logic [15:0] w;
  logic [7:0]  hb;
  assign w  = instr_i;
  assign hb = instr_i[15:8];

  logic is_mag;
  logic is_sum_shift;
  logic is_add_high;
  logic is_add_short;
  logic is_add_long;
  logic is_carry;
  logic is_nosx;
  logic is_treg;
  logic is_aux_add;
  logic is_and_shift;
  logic is_and16;
  logic is_prod;
  logic is_bsum;
  logic is_baux;
  logic is_bcond;
  assign is_mag       = w == dabd_pkg::OPC_MAGNITUDE;
  assign is_sum_shift = w[15:12] == dabd_pkg::OPC_SUM_SHIFT;
  assign is_add_high  = hb == dabd_pkg::OPC_ADD_HIGH;
  assign is_add_short = hb == dabd_pkg::OPC_ADD_SHORT;
  assign is_add_long  = w[15:4] == dabd_pkg::OPC_ADD_LONG;
  assign is_carry     = hb == dabd_pkg::OPC_SUM_CARRY;
  assign is_nosx      = hb == dabd_pkg::OPC_SUM_NOSX;
  assign is_treg      = hb == dabd_pkg::OPC_SUM_TREG;
  assign is_aux_add   = hb == dabd_pkg::OPC_AUX_ADD;
  assign is_and_shift = w[15:4] == dabd_pkg::OPC_AND_SHIFT;
  assign is_and16     = w == dabd_pkg::OPC_AND_HI16;
  assign is_prod      = w == dabd_pkg::OPC_PRODUCT_SUM;
  assign is_bsum      = w == dabd_pkg::OPC_BRANCH_SUM;
  assign is_baux      = hb == dabd_pkg::OPC_BRANCH_AUX;
  assign is_bcond     = w[15:10] == dabd_pkg::OPC_COND_BRANCH;

  // =========================================================
  // condition evaluation
  logic [1:0] tsel;
  logic [3:0] mask;
  logic [3:0] want;
  logic [3:0] match;
  logic       tsel_met;
  logic       flags_met;
  logic       cond_met;
  assign tsel = w[9:8];
  assign mask = w[3:0];
  assign want = w[7:4];
  // flags ordered z l v c
  assign match = ~(cond_i.condition_flags_field ^ want);
  assign tsel_met =
    (tsel == dabd_pkg::TSEL_PIN_LOW)  ? ~cond_i.branch_io_pin :
    (tsel == dabd_pkg::TSEL_FLAG_SET) ?  cond_i.test_control_flag :
    (tsel == dabd_pkg::TSEL_FLAG_CLR) ? ~cond_i.test_control_flag :
                                        1'b0;
  assign flags_met = |(mask & match);
  // carry and overflow branches via mask
  assign cond_met = tsel_met | flags_met;

  // =========================================================
  // classification
  dabd_pkg::dabd_op_e op_dec;
  assign op_dec =
    is_mag       ? dabd_pkg::OP_MAGNITUDE :
    is_prod      ? dabd_pkg::OP_PRODUCT_TO_ACC_SUM :
    is_bsum      ? dabd_pkg::OP_BRANCH_VIA_SUM_REG :
    is_and16     ? dabd_pkg::OP_AND_IMM_HI16 :
    is_add_long  ? dabd_pkg::OP_ADD_LONG_IMM :
    is_and_shift ? dabd_pkg::OP_AND_IMM_SHIFT :
    is_sum_shift ? dabd_pkg::OP_ACC_SUM_SHIFT :
    is_add_high  ? dabd_pkg::OP_ADD_HIGH :
    is_add_short ? dabd_pkg::OP_ADD_SHORT_IMM :
    is_carry     ? dabd_pkg::OP_ACC_SUM_WITH_CARRY :
    is_nosx      ? dabd_pkg::OP_ACC_SUM_NO_SIGN_EXT :
    is_treg      ? dabd_pkg::OP_ACC_SUM_TEMPREG_SHIFT :
    is_aux_add   ? dabd_pkg::OP_AUX_REG_ADD_IMM :
    is_baux      ? dabd_pkg::OP_BRANCH_AUX_NONZERO :
    is_bcond     ? dabd_pkg::OP_CONDITIONAL_BRANCH :
                   dabd_pkg::OP_UNKNOWN;

  logic is_branch;
  logic two_word;
  logic dec_taken;
  assign is_branch = is_bsum | is_baux | is_bcond;
  assign two_word  = is_add_long | is_and_shift | is_and16 | is_baux |
                     is_bcond;
  assign dec_taken = is_bsum | (is_baux & cond_i.aux_nonzero) |
                     (is_bcond & cond_met);

  logic [1:0] dec_words;
  logic [2:0] dec_cycles;
  assign dec_words = two_word ? dabd_pkg::WORDS_TWO : dabd_pkg::WORDS_ONE;
  // pin branch not taken takes 3
  assign dec_cycles =
    !is_branch ? (two_word ? dabd_pkg::CYC_IMM_LONG
                           : dabd_pkg::CYC_SINGLE) :
    dec_taken  ? dabd_pkg::CYC_TAKEN :
    (is_bcond && tsel == dabd_pkg::TSEL_PIN_LOW) ? dabd_pkg::CYC_PIN_NTAKEN :
                 dabd_pkg::CYC_NOT_TAKEN;

  // =========================================================
  // sequencer
  dabd_state_e            state;
  dabd_state_e            next_state;
  dabd_pkg::dabd_result_s cur;
  dabd_pkg::dabd_result_s next_cur;
  logic [2:0]             cnt;
  logic [2:0]             next_cnt;
  logic                   enable;
  logic                   take;
  logic                   fin;
  logic                   next_done;

  assign take = instr_valid_i & instr_ready_o;

  always_comb begin
    next_state = state;
    next_cur   = cur;
    next_cnt   = cnt;
    next_done  = 1'b0;
    case (state)
      ST_OPCODE: begin
        if (take) begin
          next_cur.op                 = op_dec;
          next_cur.taken              = dec_taken;
          next_cur.words              = dec_words;
          next_cur.cycles             = dec_cycles;
          next_cur.shift_amount_field = w[11:8];
          next_cur.low_field          = w[7:0];
          next_cur.second_word        = 16'h0000;
          // shift in low nibble for add long and and shift forms
          if (is_add_long || is_and_shift) begin
            next_cur.shift_amount_field = w[3:0];
          end
          next_cnt = dec_cycles - 3'h1;
          if (two_word) begin
            next_state = ST_OPERAND;
          end else if (dec_cycles != dabd_pkg::CYC_SINGLE) begin
            next_state = ST_EXEC;
          end else begin
            next_done = 1'b1;
          end
        end
      end
      ST_OPERAND: begin
        if (take) begin
          next_cur.second_word = w;
          next_cnt             = cnt - 3'h1;
          if (cnt == 3'h1) begin
            next_state = ST_OPCODE;
            next_done  = 1'b1;
          end else begin
            next_state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          next_state = ST_OPCODE;
          next_done  = 1'b1;
        end
      end
      default: begin
        next_state = ST_OPCODE;
      end
    endcase
  end

  assign fin = next_done;

  // =========================================================
  // fetch handshake
  logic next_ready;
  assign next_ready = enable & (next_state != ST_EXEC);

  // =========================================================
  // sequencer registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state         <= ST_OPCODE;
      cur           <= '0;
      cnt           <= 3'h0;
      done_o        <= 1'b0;
      result_o      <= '0;
      instr_ready_o <= 1'b0;
    end else begin
      state         <= next_state;
      cur           <= next_cur;
      cnt           <= next_cnt;
      done_o        <= next_done;
      instr_ready_o <= next_ready;
      if (next_done) begin
        result_o <= next_cur;
      end
    end
  end

  // =========================================================
  // avalon slave, one wait state
  logic        req;
  logic        acc;
  logic        wr_ok;
  logic [3:0]  byte_ofs;
  logic        sel_ctrl;
  logic        sel_status;
  logic        sel_result;
  logic        sel_count;
  logic        illegal;
  logic        cnt_clr;
  logic        ill_clr;
  logic        ill_set;
  logic [15:0] dec_count;

  assign req        = avs_read_i | avs_write_i;
  assign acc        = req & avs_waitrequest_o;
  assign wr_ok      = avs_write_i & ~avs_waitrequest_o &
                      avs_byteenable_i[0];
  assign byte_ofs   = {avs_address_i, 2'h0};
  assign sel_ctrl   = byte_ofs == dabd_pkg::REG_CTRL_OFS;
  assign sel_status = byte_ofs == dabd_pkg::REG_STATUS_OFS;
  assign sel_result = byte_ofs == dabd_pkg::REG_RESULT_OFS;
  assign sel_count  = byte_ofs == dabd_pkg::REG_COUNT_OFS;
  assign cnt_clr = wr_ok & sel_ctrl &
                   avs_writedata_i[dabd_pkg::CTRL_CNT_CLR_BIT];
  assign ill_clr = wr_ok & sel_ctrl &
                   avs_writedata_i[dabd_pkg::CTRL_ILL_CLR_BIT];
  assign ill_set = fin & (next_cur.op == dabd_pkg::OP_UNKNOWN);

  // =========================================================
  // register read packing
  logic [31:0] status_word;
  logic [31:0] result_word;
  logic [31:0] rd_mux;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[dabd_pkg::ST_OP_LSB +: 5]    = result_o.op;
    status_word[dabd_pkg::ST_CYC_LSB +: 3]   = result_o.cycles;
    status_word[dabd_pkg::ST_WORDS_LSB +: 2] = result_o.words;
    status_word[dabd_pkg::ST_TAKEN_BIT]      = result_o.taken;
    status_word[dabd_pkg::ST_BUSY_BIT]       = state != ST_OPCODE;
    status_word[dabd_pkg::ST_ILLEGAL_BIT]    = illegal;
    result_word = 32'h0000_0000;
    result_word[dabd_pkg::RS_OPND_LSB +: 16] = result_o.second_word;
    result_word[dabd_pkg::RS_FIELD_LSB +: 8] = result_o.low_field;
    result_word[dabd_pkg::RS_SHIFT_LSB +: 4] =
      result_o.shift_amount_field;
  end

  assign rd_mux = sel_ctrl   ? {31'h0000_0000, enable} :
                  sel_status ? status_word :
                  sel_result ? result_word :
                  sel_count  ? {16'h0000, dec_count} :
                               32'h0000_0000;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= ~acc;
      if (acc && avs_read_i) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // =========================================================
  // register write side
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      enable <= dabd_pkg::CTRL_ENABLE_RST;
    end else if (wr_ok && sel_ctrl) begin
      enable <= avs_writedata_i[dabd_pkg::CTRL_ENABLE_BIT];
    end
  end

  // set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      illegal <= 1'b0;
    end else if (ill_set) begin
      illegal <= 1'b1;
    end else if (ill_clr) begin
      illegal <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dec_count <= 16'h0000;
    end else if (cnt_clr) begin
      dec_count <= {15'h0000, fin};
    end else if (fin) begin
      dec_count <= dec_count + 16'h0001;
    end
  end

endmodule

/* File: logic/dabd_pkg.sv */
package dabd_pkg;

  // =========================================================
  // register map (Avalon word addresses are byte offsets / 4)
  localparam logic [3:0] REG_CTRL_OFS   = 4'h0;
  localparam logic [3:0] REG_STATUS_OFS = 4'h4;
  localparam logic [3:0] REG_RESULT_OFS = 4'h8;
  localparam logic [3:0] REG_COUNT_OFS  = 4'hC;

  // control bits
  localparam int CTRL_ENABLE_BIT    = 0;
  localparam int CTRL_CNT_CLR_BIT   = 1;
  localparam int CTRL_ILL_CLR_BIT   = 2;
  localparam logic CTRL_ENABLE_RST  = 1'b1;

  // status field positions
  localparam int ST_OP_LSB     = 0;
  localparam int ST_CYC_LSB    = 8;
  localparam int ST_WORDS_LSB  = 12;
  localparam int ST_TAKEN_BIT  = 16;
  localparam int ST_BUSY_BIT   = 17;
  localparam int ST_ILLEGAL_BIT = 18;

  // result field positions
  localparam int RS_OPND_LSB   = 0;
  localparam int RS_FIELD_LSB  = 16;
  localparam int RS_SHIFT_LSB  = 24;

  // =========================================================
  // opcode patterns
  localparam logic [15:0] OPC_MAGNITUDE   = 16'hBE00;
  localparam logic [15:0] OPC_PRODUCT_SUM = 16'hBE04;
  localparam logic [15:0] OPC_BRANCH_SUM  = 16'hBE20;
  localparam logic [15:0] OPC_AND_HI16    = 16'hBE81;
  localparam logic [3:0]  OPC_SUM_SHIFT   = 4'h2;
  localparam logic [7:0]  OPC_ADD_HIGH    = 8'h61;
  localparam logic [7:0]  OPC_ADD_SHORT   = 8'hB8;
  localparam logic [11:0] OPC_ADD_LONG    = 12'hBF9;
  localparam logic [7:0]  OPC_SUM_CARRY   = 8'h60;
  localparam logic [7:0]  OPC_SUM_NOSX    = 8'h62;
  localparam logic [7:0]  OPC_SUM_TREG    = 8'h63;
  localparam logic [7:0]  OPC_AUX_ADD     = 8'h78;
  localparam logic [11:0] OPC_AND_SHIFT   = 12'hBFB;
  localparam logic [7:0]  OPC_BRANCH_AUX  = 8'h7B;
  localparam logic [5:0]  OPC_COND_BRANCH = 6'h38;

  // test select encodings
  localparam logic [1:0] TSEL_PIN_LOW  = 2'h0;
  localparam logic [1:0] TSEL_FLAG_SET = 2'h1;
  localparam logic [1:0] TSEL_FLAG_CLR = 2'h2;

  // =========================================================
  // words / cycles figures
  localparam logic [1:0] WORDS_ONE      = 2'h1;
  localparam logic [1:0] WORDS_TWO      = 2'h2;
  localparam logic [2:0] CYC_SINGLE     = 3'h1;
  localparam logic [2:0] CYC_IMM_LONG   = 3'h2;
  localparam logic [2:0] CYC_TAKEN      = 3'h4;
  localparam logic [2:0] CYC_NOT_TAKEN  = 3'h2;
  localparam logic [2:0] CYC_PIN_NTAKEN = 3'h3;

  typedef enum logic [4:0] {
    OP_UNKNOWN,
    OP_MAGNITUDE,
    OP_ACC_SUM_SHIFT,
    OP_ADD_HIGH,
    OP_ADD_SHORT_IMM,
    OP_ADD_LONG_IMM,
    OP_ACC_SUM_WITH_CARRY,
    OP_ACC_SUM_NO_SIGN_EXT,
    OP_ACC_SUM_TEMPREG_SHIFT,
    OP_AUX_REG_ADD_IMM,
    OP_AND_IMM_SHIFT,
    OP_AND_IMM_HI16,
    OP_PRODUCT_TO_ACC_SUM,
    OP_BRANCH_VIA_SUM_REG,
    OP_BRANCH_AUX_NONZERO,
    OP_CONDITIONAL_BRANCH
  } dabd_op_e;

  typedef struct packed {
    dabd_op_e    op;
    logic        taken;
    logic [1:0]  words;
    logic [2:0]  cycles;
    logic [3:0]  shift_amount_field;
    logic [7:0]  low_field;
    logic [15:0] second_word;
  } dabd_result_s;

  typedef struct packed {
    logic [3:0] condition_flags_field;
    logic       test_control_flag;
    logic       branch_io_pin;
    logic       aux_nonzero;
  } dabd_cond_s;

endpackage

/* File: testbench/dabd_decoder_monitor.sv */
`timescale 1ns/100ps
module dabd_decoder_monitor (
  input wire logic                   clk_sys_i,
  input wire logic                   rst_n_i,
  input wire logic [15:0]            instr_i,
  input wire logic                   instr_valid_i,
  input wire logic                   instr_ready_o,
  input wire dabd_pkg::dabd_result_s result_o,
  input wire logic                   done_o,
  input wire logic                   avs_read_i,
  input wire logic                   avs_write_i,
  input wire logic                   avs_waitrequest_o
);
  // ==========================================
  // opcode or second word tracking
  logic        op_ph;
  logic [15:0] last_w;
  wire take = instr_valid_i && instr_ready_o;
  wire opt = take && op_ph;
  wire two_w = instr_i[15:10] == dabd_pkg::OPC_COND_BRANCH ||
    instr_i[15:8] == dabd_pkg::OPC_BRANCH_AUX ||
    instr_i[15:4] == dabd_pkg::OPC_ADD_LONG ||
    instr_i[15:4] == dabd_pkg::OPC_AND_SHIFT ||
    instr_i == dabd_pkg::OPC_AND_HI16;
  wire [4:0] op = result_o.op;
  always_ff @(posedge clk_sys_i) begin
    last_w <= instr_i;
    if (!rst_n_i) op_ph <= 1'b1;
    else if (take) op_ph <= !(op_ph && two_w);
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_wait3;
    (!instr_ready_o && !done_o)[*3];
  endsequence
  sequence s_fin;
    done_o && instr_ready_o;
  endsequence
  a_one_wait: assert property (s_req |=> !avs_waitrequest_o)
    else $error("wait state count wrong");
  a_wait_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_rst_quiet: assert property ($rose(rst_n_i) |-> !instr_ready_o && !done_o)
    else $error("fetch active after reset");
  a_mag_time: assert property (
    opt && instr_i == dabd_pkg::OPC_MAGNITUDE |=> done_o &&
    op == dabd_pkg::OP_MAGNITUDE && result_o.cycles == dabd_pkg::CYC_SINGLE)
    else $error("magnitude decode wrong");
  a_bsum_time: assert property (
    opt && instr_i == dabd_pkg::OPC_BRANCH_SUM |=> s_wait3 ##1 s_fin)
    else $error("accumulator branch timing wrong");
  a_short_imm: assert property (
    opt && instr_i[15:8] == dabd_pkg::OPC_ADD_SHORT |=> done_o &&
    op == dabd_pkg::OP_ADD_SHORT_IMM && result_o.low_field == last_w[7:0])
    else $error("short immediate wrong");
  a_long_cnt: assert property (
    done_o && op inside {dabd_pkg::OP_ADD_LONG_IMM, dabd_pkg::OP_AND_IMM_SHIFT,
    dabd_pkg::OP_AND_IMM_HI16} |-> result_o.words == dabd_pkg::WORDS_TWO &&
    result_o.cycles == dabd_pkg::CYC_IMM_LONG)
    else $error("two word counts wrong");
  a_aux_cnt: assert property (
    done_o && op == dabd_pkg::OP_BRANCH_AUX_NONZERO |-> result_o.cycles ==
    (result_o.taken ? dabd_pkg::CYC_TAKEN : dabd_pkg::CYC_NOT_TAKEN))
    else $error("aux branch cycles wrong");
  a_cond_cnt: assert property (
    done_o && op == dabd_pkg::OP_CONDITIONAL_BRANCH && result_o.taken |->
    result_o.cycles == dabd_pkg::CYC_TAKEN)
    else $error("taken branch cycles wrong");
endmodule
bind dabd_decoder dabd_decoder_monitor u_mon (.clk_sys_i, .rst_n_i,
  .instr_i, .instr_valid_i, .instr_ready_o, .result_o, .done_o,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o);

/* File: testbench/dabd_decoder_tb.sv */
`timescale 1ns/100ps
module dabd_decoder_tb;
  logic                   clk_sys_i, rst_n_i, vld, rdy, done_o, wreq;
  logic                   avs_read_i, avs_write_i;
  logic [15:0]            word;
  logic [1:0]             adr, gap;
  logic [3:0]             be;
  logic [31:0]            wd, rdat, rq;
  dabd_pkg::dabd_cond_s   cond_i;
  dabd_pkg::dabd_result_s res;
  int                     n_mismatch, checks_done, cyc, ndone;
  dabd_decoder u_dut (.clk_sys_i, .rst_n_i, .instr_i(word),
    .instr_valid_i(vld), .instr_ready_o(rdy), .cond_i, .result_o(res),
    .done_o, .avs_address_i(adr), .avs_read_i, .avs_write_i,
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq));
  dabd_fetch_model u_mem (.clk_sys_i, .rst_n_i, .ready_i(rdy),
    .gap_i(gap), .valid_o(vld), .word_o(word));
  // ==========================================
  // tasks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_sys_i); while (wreq !== 1'b0);
    rq = rdat;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic run(input logic [15:0] w0, w1, input logic [6:0] c,
    input logic [4:0] op, input logic [1:0] nw, input logic [2:0] cy,
    input int tk);
    @(posedge clk_sys_i);
    cond_i <= c;
    @(negedge clk_sys_i);
    u_mem.push(w0);
    if (nw == 2'h2) u_mem.push(w1);
    do @(posedge clk_sys_i); while (done_o !== 1'b1);
    ndone++;
    chk("op", res.op, op);
    chk("words", res.words, nw);
    chk("cycles", res.cycles, cy);
    if (tk < 2) chk("taken", res.taken, tk[0]);
    if (nw == 2'h2) chk("second", res.second_word, w1);
  endtask
  // ==========================================
  // clock, timeout, sequence
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    {rst_n_i, avs_read_i, avs_write_i, adr, wd, gap} = '0;
    be = 4'hF;
    cond_i = '0;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    av(1'b0, 2'h0, 32'h0);
    chk("ctrl", rq, 32'h1);
    run(16'hBE00, 16'h0, 7'h02, 5'h01, 2'h1, 3'h1, 2);
    run(16'h2A35, 16'h0, 7'h02, 5'h02, 2'h1, 3'h1, 2);
    chk("shift", res.shift_amount_field, 4'hA);
    chk("addr", res.low_field, 8'h35);
    run(16'h6112, 16'h0, 7'h02, 5'h03, 2'h1, 3'h1, 2);
    run(16'hB8F0, 16'h0, 7'h02, 5'h04, 2'h1, 3'h1, 2);
    chk("imm", res.low_field, 8'hF0);
    run(16'hBF97, 16'h1234, 7'h02, 5'h05, 2'h2, 3'h2, 2);
    chk("shift", res.shift_amount_field, 4'h7);
    run(16'h6000, 16'h0, 7'h02, 5'h06, 2'h1, 3'h1, 2);
    run(16'h6200, 16'h0, 7'h02, 5'h07, 2'h1, 3'h1, 2);
    run(16'h6300, 16'h0, 7'h02, 5'h08, 2'h1, 3'h1, 2);
    run(16'h7805, 16'h0, 7'h02, 5'h09, 2'h1, 3'h1, 2);
    run(16'hBFB3, 16'hABCD, 7'h02, 5'h0A, 2'h2, 3'h2, 2);
    run(16'hBE81, 16'h5555, 7'h02, 5'h0B, 2'h2, 3'h2, 2);
    run(16'hBE04, 16'h0, 7'h02, 5'h0C, 2'h1, 3'h1, 2);
    run(16'hBE20, 16'h0, 7'h02, 5'h0D, 2'h1, 3'h4, 1);
    run(16'h7B10, 16'h0100, 7'h02, 5'h0E, 2'h2, 3'h2, 0);
    run(16'h7B10, 16'h0100, 7'h03, 5'h0E, 2'h2, 3'h4, 1);
    $display("test plain decode done");
    run(16'hE100, 16'h0200, 7'h06, 5'h0F, 2'h2, 3'h4, 1);
    run(16'hE100, 16'h0200, 7'h02, 5'h0F, 2'h2, 3'h2, 0);
    run(16'hE200, 16'h0200, 7'h02, 5'h0F, 2'h2, 3'h4, 1);
    run(16'hE38C, 16'h0300, 7'h02, 5'h0F, 2'h2, 3'h4, 1);
    run(16'hE38C, 16'h0300, 7'h22, 5'h0F, 2'h2, 3'h2, 0);
    run(16'hE304, 16'h0300, 7'h22, 5'h0F, 2'h2, 3'h2, 0);
    run(16'hE3CC, 16'h0300, 7'h42, 5'h0F, 2'h2, 3'h4, 1);
    run(16'hE344, 16'h0300, 7'h22, 5'h0F, 2'h2, 3'h4, 1);
    run(16'hE311, 16'h0400, 7'h0A, 5'h0F, 2'h2, 3'h4, 1);
    run(16'hE301, 16'h0400, 7'h0A, 5'h0F, 2'h2, 3'h2, 0);
    run(16'hE302, 16'h0400, 7'h12, 5'h0F, 2'h2, 3'h2, 0);
    run(16'hE302, 16'h0400, 7'h02, 5'h0F, 2'h2, 3'h4, 1);
    run(16'hE000, 16'h0500, 7'h00, 5'h0F, 2'h2, 3'h4, 1);
    run(16'hE000, 16'h0500, 7'h02, 5'h0F, 2'h2, 3'h3, 0);
    run(16'hE300, 16'h0500, 7'h7C, 5'h0F, 2'h2, 3'h2, 0);
    $display("test branches done");
    @(posedge clk_sys_i);
    gap <= 2'h2;
    run(16'hBF97, 16'h4321, 7'h02, 5'h05, 2'h2, 3'h2, 2);
    gap <= 2'h0;
    @(negedge clk_sys_i);
    u_mem.push(16'hBE00);
    u_mem.push(16'hBE04);
    do @(posedge clk_sys_i); while (done_o !== 1'b1);
    @(posedge clk_sys_i);
    chk("b2b", {done_o, res.op}, {1'b1, 5'h0C});
    ndone += 2;
    run(16'hFFFF, 16'h0, 7'h02, 5'h00, 2'h1, 3'h1, 2);
    $display("test stall and back to back done");
    av(1'b0, 2'h3, 32'h0);
    chk("count", rq, ndone);
    av(1'b0, 2'h1, 32'h0);
    chk("illegal", rq[dabd_pkg::ST_ILLEGAL_BIT], 1'b1);
    av(1'b1, 2'h0, 32'h7);
    av(1'b0, 2'h3, 32'h0);
    chk("count clr", rq, 32'h0);
    av(1'b0, 2'h1, 32'h0);
    chk("illegal clr", rq[dabd_pkg::ST_ILLEGAL_BIT], 1'b0);
    be <= 4'h0;
    av(1'b1, 2'h0, 32'h0);
    be <= 4'hF;
    av(1'b0, 2'h0, 32'h0);
    chk("ctrl kept", rq, 32'h1);
    av(1'b1, 2'h0, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    chk("ready off", rdy, 1'b0);
    av(1'b1, 2'h0, 32'h1);
    $display("test registers done");
    end_of_test();
  end
endmodule

/* File: testbench/dabd_fetch_model.sv */
`timescale 1ns/100ps
module dabd_fetch_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        ready_i,
  input  wire logic [1:0]  gap_i,
  output logic             valid_o,
  output logic [15:0]      word_o
);
  logic [15:0] q[$];
  int          n;
  logic        tk;
  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask
  initial begin
    valid_o = 1'b0;
    word_o = 16'h0000;
    n = 0;
  end
  // ==========================================
  // word presenter, idle word toggles
  always @(posedge clk_sys_i) begin
    tk = valid_o && ready_i;
    if (tk) begin
      void'(q.pop_front());
      n = gap_i;
    end
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      n = 0;
    end else if (!valid_o || tk) begin
      if (n == 0 && q.size() != 0) begin
        valid_o <= 1'b1;
        word_o <= q[0];
      end else begin
        valid_o <= 1'b0;
        word_o <= ~word_o;
        if (!tk && n != 0) n = n - 1;
      end
    end
  end
endmodule
